// *** cpu_regs_pkg.sv ***
// -----------------------------------------------------------------------------
// Shared constants for the dedicated CPU register set
// -----------------------------------------------------------------------------
package cpu_regs_pkg;
  localparam int unsigned DATA_W = 16;    // Every dedicated register is 16 bits
  localparam int unsigned BYTE_W = 8;     // Short data operations use the low byte
  localparam int unsigned ADDR_W = 4;     // Register port address width
  localparam int unsigned LVL_W = 2;      // Interrupt level code width
  localparam int unsigned SEL_W = 3;      // General register select width

  // Register port offsets
  localparam logic [3:0] OFS_PC = 4'h0;
  localparam logic [3:0] OFS_ACC = 4'h1;
  localparam logic [3:0] OFS_TMP = 4'h2;
  localparam logic [3:0] OFS_IDX = 4'h3;
  localparam logic [3:0] OFS_EXT = 4'h4;
  localparam logic [3:0] OFS_STK = 4'h5;
  localparam logic [3:0] OFS_PSW = 4'h6;
  localparam logic [3:0] OFS_STAT = 4'h7;

  // Program status word layout
  localparam int unsigned PSW_BANK_LO = 8;
  localparam int unsigned PSW_BANK_W = 8;
  localparam int unsigned BANK_NUM_W = 4; // Sixteen banks reachable
  localparam int unsigned FLG_H = 7;
  localparam int unsigned FLG_I = 6;
  localparam int unsigned FLG_MASK = 4;   // Two bits, 5:4
  localparam int unsigned FLG_N = 3;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_V = 1;
  localparam int unsigned FLG_C = 0;

  // Status read layout
  localparam int unsigned ST_PC_AREA = 0;  // Two bits
  localparam int unsigned ST_XP_AREA = 2;  // Two bits
  localparam int unsigned ST_IRQ = 4;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] PSW_RESET = 16'h0000;   // Interrupts disabled

  // Memory map of the 64 Kbyte space, low to high
  localparam logic [15:0] IO_TOP = 16'h007F;
  localparam logic [15:0] DATA_TOP = 16'h3FFF;
  localparam logic [15:0] PROG_BASE = 16'h8000;
  localparam logic [15:0] BANK_BASE = 16'h0100;   // First register bank in data area
  localparam int unsigned BANK_SHIFT = 3;         // Eight registers per bank

  typedef enum logic [1:0] {AREA_IO, AREA_DATA, AREA_FREE, AREA_PROG} area_t;
  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_SHL, ALU_SHR} alu_op_t;
endpackage : cpu_regs_pkg

// *** cpu_dedicated_registers_ccr.sv ***
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module cpu_dedicated_registers_ccr (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [cpu_regs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cpu_regs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cpu_regs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pc_step,
  input wire logic pc_load,
  input wire logic [cpu_regs_pkg::DATA_W-1:0] pc_load_val,
  input wire logic alu_go,
  input wire cpu_regs_pkg::alu_op_t alu_op,
  input wire logic alu_wide,
  input wire logic irq_req,
  input wire logic [cpu_regs_pkg::LVL_W-1:0] irq_level,
  output logic irq_accept,
  input wire logic [cpu_regs_pkg::SEL_W-1:0] gp_reg_sel,
  output logic [cpu_regs_pkg::DATA_W-1:0] gp_reg_addr,
  output logic [cpu_regs_pkg::DATA_W-1:0] instr_counter,
  output logic [cpu_regs_pkg::DATA_W-1:0] work_acc,
  output logic [cpu_regs_pkg::DATA_W-1:0] temp_acc,
  output logic [cpu_regs_pkg::DATA_W-1:0] index_reg,
  output logic [cpu_regs_pkg::DATA_W-1:0] extra_pointer,
  output logic [cpu_regs_pkg::DATA_W-1:0] stack_top_ptr,
  output logic [cpu_regs_pkg::DATA_W-1:0] program_status_word
);
  import cpu_regs_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------

  // Write hit on one register offset
  function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction : wr_hit

  // Which area of the address space an address falls in
  function automatic area_t area_of(input logic [15:0] a);
    if (a <= IO_TOP) begin
      area_of = AREA_IO;
    end else if (a <= DATA_TOP) begin
      area_of = AREA_DATA;
    end else if (a >= PROG_BASE) begin
      area_of = AREA_PROG;
    end else begin
      area_of = AREA_FREE;
    end
  endfunction : area_of

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [15:0] pc_q;       // Instruction counter
  logic [15:0] acc_q;      // Working accumulator
  logic [15:0] tmp_q;      // Temporary accumulator
  logic [15:0] idx_q;      // Index register
  logic [15:0] ext_q;      // Extra pointer
  logic [15:0] stk_q;      // Stack top pointer
  logic [7:0] bank_q;      // Register bank pointer, status high byte
  logic [7:0] cond_q;      // Condition codes, status low byte
  logic [15:0] gpa_q;      // Registered general register address
  logic [15:0] rdata_q;    // Read data, one cycle after the strobe

  // ALU results
  logic [15:0] alu_res;    // Result written back to the accumulator
  logic h_d;               // Half carry
  logic n_d;               // Negative
  logic z_d;               // Zero
  logic v_d;               // Overflow
  logic c_d;               // Carry
  logic arith;             // Add or subtract, not a shift

  // ---------------------------------------------------------------------------
  // Instruction counter
  // ---------------------------------------------------------------------------

  // Bus write beats a core load, which beats a step; the core never
  // steps while software is patching the counter.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pc_q <= PC_RESET;
    end else if (wr_hit(reg_wr, reg_addr, OFS_PC)) begin
      pc_q <= reg_wdata;
    end else if (pc_load) begin
      pc_q <= pc_load_val;
    end else if (pc_step) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Arithmetic and flags
  // ---------------------------------------------------------------------------

  // Flag generation for add, subtract and one-bit shifts on the
  // accumulator, with the temporary accumulator as second operand
  always_comb begin
    logic [16:0] s;
    logic [15:0] a;
    logic [15:0] b;
    logic am;
    logic bm;
    logic rm;
    s = 17'h00000;
    a = alu_wide ? acc_q : {8'h00, acc_q[7:0]};
    b = alu_wide ? tmp_q : {8'h00, tmp_q[7:0]};
    arith = (alu_op == ALU_ADD) || (alu_op == ALU_SUB);
    c_d = 1'b0;
    case (alu_op)
      ALU_ADD: begin
        s = {1'b0, a} + {1'b0, b};
      end
      ALU_SUB: begin
        s = {1'b0, a} - {1'b0, b};
      end
      ALU_SHL: begin
        s = {1'b0, a[14:0], 1'b0};
        c_d = alu_wide ? a[15] : a[7];
      end
      ALU_SHR: begin
        s = alu_wide ? {2'b00, a[15:1]} : {10'h000, a[7:1]};
        c_d = a[0];
      end
      default: begin
        s = 17'h00000;
      end
    endcase
    // Carry out of the top bit of the operation width
    if (arith) begin
      c_d = alu_wide ? s[16] : s[8];
    end
    // Carry into bit 4 is the sum bit against both operand bits
    h_d = arith && (a[4] ^ b[4] ^ s[4]);
    am = alu_wide ? a[15] : a[7];
    bm = alu_wide ? b[15] : b[7];
    rm = alu_wide ? s[15] : s[7];
    n_d = rm;
    z_d = alu_wide ? (s[15:0] == 16'h0000) : (s[7:0] == 8'h00);
    // Same-sign add or mixed-sign subtract that flips the sign
    if (alu_op == ALU_ADD) begin
      v_d = (am == bm) && (rm != am);
    end else if (alu_op == ALU_SUB) begin
      v_d = (am != bm) && (rm != am);
    end else begin
      v_d = 1'b0;
    end
    // Short operations leave the accumulator high byte alone
    alu_res = alu_wide ? s[15:0] : {acc_q[15:8], s[7:0]};
  end

  // ---------------------------------------------------------------------------
  // Accumulators and pointers
  // ---------------------------------------------------------------------------

  // Accumulator: a core operation wins over a bus write in the same
  // cycle, so a result is never lost to software
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc_q <= REG_RESET;
    end else if (alu_go) begin
      acc_q <= alu_res;
    end else if (wr_hit(reg_wr, reg_addr, OFS_ACC)) begin
      acc_q <= reg_wdata;
    end
  end

  // Temporary accumulator
  always_ff @(posedge mclk) begin
    if (reset) begin
      tmp_q <= REG_RESET;
    end else if (wr_hit(reg_wr, reg_addr, OFS_TMP)) begin
      tmp_q <= reg_wdata;
    end
  end

  // Index register
  always_ff @(posedge mclk) begin
    if (reset) begin
      idx_q <= REG_RESET;
    end else if (wr_hit(reg_wr, reg_addr, OFS_IDX)) begin
      idx_q <= reg_wdata;
    end
  end

  // Extra pointer
  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_q <= REG_RESET;
    end else if (wr_hit(reg_wr, reg_addr, OFS_EXT)) begin
      ext_q <= reg_wdata;
    end
  end

  // Stack top pointer
  always_ff @(posedge mclk) begin
    if (reset) begin
      stk_q <= REG_RESET;
    end else if (wr_hit(reg_wr, reg_addr, OFS_STK)) begin
      stk_q <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Program status word
  // ---------------------------------------------------------------------------

  // Bank pointer in the high byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      bank_q <= PSW_RESET[PSW_BANK_LO +: PSW_BANK_W];
    end else if (wr_hit(reg_wr, reg_addr, OFS_PSW)) begin
      bank_q <= reg_wdata[PSW_BANK_LO +: PSW_BANK_W];
    end
  end

  // Condition codes in the low byte; the ALU updates only the
  // arithmetic flags and overrides a bus write to them, while the
  // interrupt enable and level mask still take the written value
  always_ff @(posedge mclk) begin
    if (reset) begin
      cond_q <= PSW_RESET[7:0];
    end else begin
      if (wr_hit(reg_wr, reg_addr, OFS_PSW)) begin
        cond_q <= reg_wdata[7:0];
      end
      if (alu_go) begin
        cond_q[FLG_H] <= h_d;
        cond_q[FLG_N] <= n_d;
        cond_q[FLG_Z] <= z_d;
        cond_q[FLG_V] <= v_d;
        cond_q[FLG_C] <= c_d;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt admission
  // ---------------------------------------------------------------------------

  // Lower code means higher level; a mask of 0 blocks every request
  // because no level code lies numerically below it
  assign irq_accept = irq_req && cond_q[FLG_I] && (irq_level < cond_q[FLG_MASK +: LVL_W]);

  // ---------------------------------------------------------------------------
  // General register banks
  // ---------------------------------------------------------------------------

  // Bank base plus eight bytes per bank plus the register select;
  // only the low four pointer bits reach the sixteen banks. The
  // address lags a pointer or select change by one cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      gpa_q <= BANK_BASE;
    end else begin
      gpa_q <= BANK_BASE + ({12'h000, bank_q[BANK_NUM_W-1:0]} << BANK_SHIFT) + {13'h0000, gp_reg_sel};
    end
  end

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------

  // Read data stand for exactly the cycle after the strobe; offsets
  // above the status word read as zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_PC: rdata_q <= pc_q;
        OFS_ACC: rdata_q <= acc_q;
        OFS_TMP: rdata_q <= tmp_q;
        OFS_IDX: rdata_q <= idx_q;
        OFS_EXT: rdata_q <= ext_q;
        OFS_STK: rdata_q <= stk_q;
        OFS_PSW: rdata_q <= {bank_q, cond_q};
        OFS_STAT: begin
          rdata_q <= REG_RESET;
          rdata_q[ST_PC_AREA +: 2] <= area_of(pc_q);
          rdata_q[ST_XP_AREA +: 2] <= area_of(ext_q);
          rdata_q[ST_IRQ] <= irq_accept;
        end
        default: rdata_q <= REG_RESET;
      endcase
    end else begin
      rdata_q <= REG_RESET;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign gp_reg_addr = gpa_q;
  assign instr_counter = pc_q;
  assign work_acc = acc_q;
  assign temp_acc = tmp_q;
  assign index_reg = idx_q;
  assign extra_pointer = ext_q;
  assign stack_top_ptr = stk_q;
  assign program_status_word = {bank_q, cond_q};

endmodule : cpu_dedicated_registers_ccr

// *** cpu_regs_chk_asserts.sv ***
`timescale 1ns/1ps
// ------------------------------------
// Port checker for the register set
// ------------------------------------
module cpu_regs_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic pc_step,
  input wire logic pc_load,
  input wire logic alu_go,
  input wire cpu_regs_pkg::alu_op_t alu_op,
  input wire logic alu_wide,
  input wire logic irq_req,
  input wire logic [1:0] irq_level,
  input wire logic irq_accept,
  input wire logic [2:0] gp_reg_sel,
  input wire logic [15:0] gp_reg_addr,
  input wire logic [15:0] instr_counter,
  input wire logic [15:0] work_acc,
  input wire logic [15:0] program_status_word
);
  import cpu_regs_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire [15:0] psw = program_status_word; // Short alias
  property p_rd_psw; reg_rd && reg_addr == OFS_PSW |=> reg_rdata == $past(psw); endproperty
  a_rd_psw: assert property (p_rd_psw) else $error("status word read wrong");
  property p_step; pc_step && !pc_load && !(reg_wr && reg_addr == OFS_PC)
    |=> instr_counter == $past(instr_counter) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("counter step wrong");
  property p_irq; irq_accept == (irq_req && psw[FLG_I] && irq_level < psw[5:4]); endproperty
  a_irq: assert property (p_irq) else $error("interrupt accept wrong");
  // The reset itself is watched here, so no disable
  property p_rst_i; disable iff (1'b0) reset |=> !psw[FLG_I]; endproperty
  a_rst_i: assert property (p_rst_i) else $error("enable flag not cleared");
  property p_zw; alu_go && alu_wide |=> psw[FLG_Z] == (work_acc == 16'h0000); endproperty
  a_zw: assert property (p_zw) else $error("zero flag wrong");
  property p_nw; alu_go && alu_wide |=> psw[FLG_N] == work_acc[15]; endproperty
  a_nw: assert property (p_nw) else $error("negative flag wrong");
  property p_nar; alu_go && !alu_wide |=> work_acc[15:8] == $past(work_acc[15:8])
    && psw[FLG_Z] == (work_acc[7:0] == 8'h00); endproperty
  a_nar: assert property (p_nar) else $error("short operation wrong");
  property p_shl; alu_go && alu_wide && alu_op == ALU_SHL
    |=> psw[FLG_C] == $past(work_acc[15]) && !psw[FLG_H] && !psw[FLG_V]; endproperty
  a_shl: assert property (p_shl) else $error("shift flags wrong");
  property p_gp; !reset |=> gp_reg_addr == BANK_BASE + {9'h000, $past(psw[11:8]), $past(gp_reg_sel)}; endproperty
  a_gp: assert property (p_gp) else $error("bank address wrong");
endmodule : cpu_regs_chk

bind cpu_dedicated_registers_ccr cpu_regs_chk chk_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_step(pc_step), .pc_load(pc_load),
  .alu_go(alu_go), .alu_op(alu_op), .alu_wide(alu_wide), .irq_req(irq_req), .irq_level(irq_level),
  .irq_accept(irq_accept), .gp_reg_sel(gp_reg_sel), .gp_reg_addr(gp_reg_addr),
  .instr_counter(instr_counter), .work_acc(work_acc), .program_status_word(program_status_word));

// *** cpu_dedicated_registers_ccr_tb.sv ***
`timescale 1ns/1ps
module cpu_dedicated_registers_ccr_tb;
  import cpu_regs_pkg::*;
  logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, pc_step = 0, pc_load = 0, alu_go = 0;
  logic alu_wide = 0, irq_req = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, pc_load_val = 16'h0000, a, v;
  logic [1:0] irq_level = 2'h0;
  logic [2:0] gp_reg_sel = 3'h0;
  alu_op_t alu_op = ALU_ADD;
  wire [15:0] reg_rdata, gp_reg_addr, instr_counter, work_acc, temp_acc, index_reg;
  wire [15:0] extra_pointer, stack_top_ptr, program_status_word;
  wire irq_accept;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  logic [15:0] bnd [7] = '{16'h0000, 16'h007F, 16'h0080, 16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000};

  cpu_dedicated_registers_ccr dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_step(pc_step), .pc_load(pc_load),
    .pc_load_val(pc_load_val), .alu_go(alu_go), .alu_op(alu_op), .alu_wide(alu_wide), .irq_req(irq_req),
    .irq_level(irq_level), .irq_accept(irq_accept), .gp_reg_sel(gp_reg_sel), .gp_reg_addr(gp_reg_addr),
    .instr_counter(instr_counter), .work_acc(work_acc), .temp_acc(temp_acc), .index_reg(index_reg),
    .extra_pointer(extra_pointer), .stack_top_ptr(stack_top_ptr), .program_status_word(program_status_word));

  always #20 mclk = ~mclk; // 25 MHz
  // Hang guard, far above the thousand or so cycles needed
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge mclk); reg_wr <= 1; reg_addr <= ad; reg_wdata <= d;
    @(posedge mclk); reg_wr <= 0;
  endtask : wr

  // Read data are only valid in the single cycle after the strobe
  task rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge mclk); reg_rd <= 1; reg_addr <= ad;
    @(posedge mclk); reg_rd <= 0;
    #1 d = reg_rdata;
  endtask : rd

  // Expected {H,N,Z,V,C,result}; short ops keep the high byte
  function logic [20:0] model(alu_op_t op, logic w, logic [15:0] a, logic [15:0] t);
    logic [16:0] x, y, s;
    logic [4:0] q;
    logic h, c, z, vf;
    int m;
    m = w ? 15 : 7;
    x = w ? {1'b0, a} : {9'h000, a[7:0]};
    y = w ? {1'b0, t} : {9'h000, t[7:0]};
    q = (op == ALU_SUB) ? {1'b0, a[3:0]} - {1'b0, t[3:0]} : {1'b0, a[3:0]} + {1'b0, t[3:0]};
    case (op)
      ALU_ADD: s = x + y;
      ALU_SUB: s = x - y;
      ALU_SHL: s = {x[15:0], 1'b0};
      default: s = x >> 1;
    endcase
    c = (op == ALU_SHR) ? x[0] : s[m+1];
    h = (op == ALU_ADD || op == ALU_SUB) && q[4];
    vf = (op == ALU_ADD) ? (x[m] == y[m]) && (s[m] != x[m]) : (op == ALU_SUB) && (x[m] != y[m]) && (s[m] != x[m]);
    z = w ? (s[15:0] == 16'h0000) : (s[7:0] == 8'h00);
    return {h, s[m], z, vf, c, w ? s[15:0] : {a[15:8], s[7:0]}};
  endfunction : model

  task alu(input alu_op_t op, input logic w, input logic [15:0] a0, input logic [15:0] t0);
    logic [20:0] e;
    e = model(op, w, a0, t0);
    wr(OFS_ACC, a0);
    wr(OFS_TMP, t0);
    @(posedge mclk); alu_go <= 1; alu_op <= op; alu_wide <= w;
    @(posedge mclk); alu_go <= 0;
    #1 chk(work_acc, e[15:0]);
    chk({11'h000, program_status_word[7], program_status_word[3:0]}, {11'h000, e[20:16]});
  endtask : alu

  task conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial begin
    void'($urandom(32'h88fabd34));
    repeat (3) @(posedge mclk);
    reset <= 0;
    // Every offset, mapped or not, reads zero out of reset
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], v);
      chk(v, 16'h0000);
    end
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      a = $urandom;
      wr(i[3:0], a);
      rd(i[3:0], v);
      chk(v, a);
      chk(i == 0 ? instr_counter : i == 1 ? work_acc : i == 2 ? temp_acc : i == 3 ? index_reg :
        i == 4 ? extra_pointer : i == 5 ? stack_top_ptr : program_status_word, a);
    end
    wr(4'hC, 16'hFFFF);
    rd(4'hC, v);
    chk(v, 16'h0000);
    $display("register test done");
    // Load then step, the all-ones load checks the wrap
    for (int k = 0; k < 2; k++) begin
      a = k ? 16'($urandom) : 16'hFFFF;
      @(posedge mclk); pc_load <= 1; pc_load_val <= a;
      @(posedge mclk); pc_load <= 0; pc_step <= 1;
      @(posedge mclk); pc_step <= 0;
      #1 chk(instr_counter, a + 16'h0001);
    end
    // Area boundaries seen through the status offset
    for (int k = 0; k < 7; k++) begin
      wr(OFS_PC, bnd[k]);
      wr(OFS_EXT, bnd[k]);
      rd(OFS_STAT, v);
      chk({12'h000, v[3:0]}, {12'h000, 2'(k / 2), 2'(k / 2)});
    end
    $display("counter test done");
    alu(ALU_ADD, 0, 16'h12FF, 16'h0001);
    alu(ALU_ADD, 0, 16'h007F, 16'h0001);
    alu(ALU_SUB, 1, 16'h0000, 16'h0001);
    alu(ALU_SHR, 1, 16'h8001, 16'h0000);
    for (int k = 0; k < 64; k++) alu(alu_op_t'(k[1:0]), k[2], 16'($urandom), 16'($urandom));
    $display("alu test done");
    // Every enable, mask, level and request combination
    for (int k = 0; k < 64; k++) begin
      wr(OFS_PSW, {8'h00, 1'b0, k[4], k[3:2], 4'h0});
      @(posedge mclk); irq_req <= k[5]; irq_level <= k[1:0];
      @(posedge mclk);
      #1 chk({15'h0000, irq_accept}, {15'h0000, k[5] && k[4] && k[1:0] < k[3:2]});
      rd(OFS_STAT, v);
      chk({15'h0000, v[ST_IRQ]}, {15'h0000, k[5] && k[4] && k[1:0] < k[3:2]});
    end
    @(posedge mclk); irq_req <= 0;
    for (int k = 0; k < 16; k++) begin
      a = $urandom;
      v = $urandom;
      wr(OFS_PSW, a);
      @(posedge mclk); gp_reg_sel <= v[2:0];
      repeat (2) @(posedge mclk);
      #1 chk(gp_reg_addr, BANK_BASE + {9'h000, a[11:8], v[2:0]});
    end
    $display("interrupt and bank test done");
    conclude();
  end
endmodule : cpu_dedicated_registers_ccr_tb
